/* File: logic/xbp_pkg.sv */
`default_nettype none
package xbp_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 16;
   localparam int ZONE_W = 3;
   // Zone numbers decoded by the chip selects
   localparam logic [2:0] ZONE_0 = 3'h0;
   localparam logic [2:0] ZONE_1 = 3'h1;
   localparam logic [2:0] ZONE_2 = 3'h2;
   localparam logic [2:0] ZONE_6 = 3'h6;
   localparam logic [2:0] ZONE_7 = 3'h7;
   // Cycles the strobe stays active for one access
   localparam logic [3:0] STROBE_CYCLES = 4'h2;
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic MODE_RST = 1'b0;

   typedef enum logic [3:0] {
      XBP_IDLE = 4'b0001,
      XBP_ACCESS = 4'b0010,
      XBP_HOLD = 4'b0100,
      XBP_DONE = 4'b1000
   } xbp_state_t;

   // Request from the core side
   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] zone;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } xbp_req_t;

   // External pin outputs and active-low output enables
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic data_oe_n;
      logic bus_oe_n;
      logic rd_n;
      logic wr_n;
      logic rnw;
      logic cs01_n;
      logic cs2_n;
      logic cs67_n;
      logic grant_n;
   } xbp_pins_t;
endpackage : xbp_pkg
`default_nettype wire

/* File: logic/xbp_sync.sv */
`default_nettype none
module xbp_sync
#(
   parameter logic RST_VAL = 1'b0
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
   } xbp_sync_st_t;

   xbp_sync_st_t st;
   xbp_sync_st_t next_st;

   always_comb
   begin
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
   end

   // Reset value is a constant chosen by the instantiator
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= {RST_VAL, RST_VAL};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign sync_out = st.s2;
endmodule : xbp_sync
`default_nettype wire

/* File: logic/xbp_ext_bus.sv */
`default_nettype none
// Overview of operation
// R01: Drive 19-bit address outputs, floatable.
// R02: 16-bit bidirectional data bus, floatable, pulled up off chip.
// R03: Mode high maps upper zone to the external pins.
// R04: Mode low routes upper zone to on-chip boot ROM instead.
// R05: Capture mode pin at reset into a rewritable bit; ignore later.
// R06: Outside master asserts active-low hold request to take the bus.
// R07: Release bus only after current access completes, none pending.
// R08: Grant drives acknowledge low and floats all buses and strobes. Here strobes and selects stay driven high.
// R09: Acknowledge released once hold request is released.
// R10: Outside devices drive the bus only while acknowledge is low.
// R11: Low-pair select low during zone 0 or 1 access.
// R12: Zone-two select low during zone 2 access.
// R13: High-pair select low during zone 6 or 7 access.
// R14: Read and write strobes never active together.
// R15: Read-not-write high normally, low during write cycles.
// R16: No new access while granted; requests wait until grant ends.
module xbp_ext_bus
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire xbp_pkg::xbp_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [xbp_pkg::DATA_W-1:0] rsp_rdata,
   output logic boot_rom_sel,
   input wire logic mode_wr,
   input wire logic mode_wdata,
   output logic mode_bit,
   input wire logic processor_mode_select,
   input wire logic bus_hold_request_n,
   output xbp_pkg::xbp_pins_t pins,
   input wire logic [xbp_pkg::DATA_W-1:0] ext_data_bus_in
);
   typedef struct packed {
      xbp_pkg::xbp_state_t state;
      logic [3:0] cnt;
      logic mode_bit;
      logic mode_loaded;
      logic [1:0] mode_wait;
      logic write;
      logic [2:0] zone;
      logic req_ready;
      logic rsp_valid;
      logic [xbp_pkg::DATA_W-1:0] rdata;
      logic boot_rom_sel;
      xbp_pkg::xbp_pins_t pins;
   } xbp_st_t;

   xbp_st_t st;
   xbp_st_t next_st;
   logic mode_sync;
   logic hold_req_n_sync;
   logic [xbp_pkg::DATA_W-1:0] data_sync;
   logic go_external;

   // ==========================================================
   // Pin input synchronisers
   xbp_sync #(.RST_VAL(1'b0)) u_sync_mode
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .async_in(processor_mode_select),
      .sync_out(mode_sync)
   );

   xbp_sync #(.RST_VAL(1'b1)) u_sync_hold
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .async_in(bus_hold_request_n),
      .sync_out(hold_req_n_sync)
   );

   genvar gi;
   generate
      for (gi = 0; gi < xbp_pkg::DATA_W; gi++)
      begin : g_dsync
         xbp_sync #(.RST_VAL(1'b1)) u_sync_data
         (
            .mclk(mclk),
            .reset_n(reset_n),
            .async_in(ext_data_bus_in[gi]),
            .sync_out(data_sync[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      next_st = st;
      next_st.rsp_valid = 1'b0;
      next_st.boot_rom_sel = 1'b0;
      // R05: mode latched once after reset
      // The synchroniser sits in reset too, so wait until it has filled
      next_st.mode_wait = {st.mode_wait[0], 1'b1};
      if (!st.mode_loaded && st.mode_wait[1])
      begin
         next_st.mode_bit = mode_sync;
         next_st.mode_loaded = 1'b1;
      end
      else if (st.mode_loaded && mode_wr)
      begin
         next_st.mode_bit = mode_wdata;
      end
      // R03: upper zone goes external only in processor mode
      go_external = !((req.zone == xbp_pkg::ZONE_7) && !st.mode_bit);
      case (st.state)
         xbp_pkg::XBP_IDLE:
         begin
            // R07: grant only with no access in flight or pending
            if (!hold_req_n_sync && !(req.valid && st.req_ready))
            begin
               next_st.state = xbp_pkg::XBP_HOLD;
               next_st.req_ready = 1'b0;
               // R08: acknowledge low, address and data buses floated
               next_st.pins.grant_n = 1'b0;
               next_st.pins.bus_oe_n = 1'b1;
               next_st.pins.data_oe_n = 1'b1;
            end
            else if (req.valid && st.req_ready && st.mode_loaded)
            begin
               next_st.req_ready = 1'b0;
               next_st.write = req.write;
               next_st.zone = req.zone;
               if (!go_external)
               begin
                  // R04: upper zone served by boot ROM
                  next_st.boot_rom_sel = 1'b1;
                  next_st.state = xbp_pkg::XBP_DONE;
               end
               else
               begin
                  next_st.state = xbp_pkg::XBP_ACCESS;
                  next_st.cnt = xbp_pkg::STROBE_CYCLES;
                  // R01: address driven for the access
                  next_st.pins.addr = req.addr;
                  next_st.pins.bus_oe_n = 1'b0;
                  // R02: data driven only on writes
                  next_st.pins.data = req.wdata;
                  next_st.pins.data_oe_n = !req.write;
                  // R14: exactly one strobe active
                  next_st.pins.rd_n = req.write;
                  next_st.pins.wr_n = !req.write;
                  // R15: low only during writes
                  next_st.pins.rnw = !req.write;
                  // R11: zones 0 and 1 share a select
                  next_st.pins.cs01_n = !((req.zone == xbp_pkg::ZONE_0)
                     || (req.zone == xbp_pkg::ZONE_1));
                  // R12: zone 2 select
                  next_st.pins.cs2_n = !(req.zone == xbp_pkg::ZONE_2);
                  // R13: zones 6 and 7 share a select
                  next_st.pins.cs67_n = !((req.zone == xbp_pkg::ZONE_6)
                     || (req.zone == xbp_pkg::ZONE_7));
               end
            end
         end
         xbp_pkg::XBP_ACCESS:
         begin
            // R07: access runs to completion before any grant
            if (st.cnt == 4'h1)
            begin
               next_st.state = xbp_pkg::XBP_DONE;
               next_st.pins.rd_n = 1'b1;
               next_st.pins.wr_n = 1'b1;
               next_st.pins.rnw = 1'b1;
               next_st.pins.cs01_n = 1'b1;
               next_st.pins.cs2_n = 1'b1;
               next_st.pins.cs67_n = 1'b1;
               next_st.pins.data_oe_n = 1'b1;
            end
            else
            begin
               next_st.cnt = st.cnt - 4'h1;
            end
         end
         xbp_pkg::XBP_DONE:
         begin
            // Data pins lag two cycles through the synchroniser
            if (!st.write)
            begin
               next_st.rdata = data_sync;
            end
            next_st.rsp_valid = 1'b1;
            next_st.req_ready = 1'b1;
            next_st.state = xbp_pkg::XBP_IDLE;
         end
         xbp_pkg::XBP_HOLD:
         begin
            // R16: requests wait while the grant lasts
            next_st.req_ready = 1'b0;
            // R09: acknowledge follows request release
            if (hold_req_n_sync)
            begin
               next_st.pins.grant_n = 1'b1;
               next_st.req_ready = 1'b1;
               next_st.state = xbp_pkg::XBP_IDLE;
            end
         end
         default:
         begin
            next_st.state = xbp_pkg::XBP_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.state <= xbp_pkg::XBP_IDLE;
         st.cnt <= xbp_pkg::CNT_RST;
         st.mode_bit <= xbp_pkg::MODE_RST;
         st.req_ready <= 1'b1;
         // Buses float and strobes idle high out of reset
         st.pins.bus_oe_n <= 1'b1;
         st.pins.data_oe_n <= 1'b1;
         st.pins.rd_n <= 1'b1;
         st.pins.wr_n <= 1'b1;
         st.pins.rnw <= 1'b1;
         st.pins.cs01_n <= 1'b1;
         st.pins.cs2_n <= 1'b1;
         st.pins.cs67_n <= 1'b1;
         st.pins.grant_n <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign req_ready = st.req_ready;
   assign rsp_valid = st.rsp_valid;
   assign rsp_rdata = st.rdata;
   assign boot_rom_sel = st.boot_rom_sel;
   assign mode_bit = st.mode_bit;
   assign pins = st.pins;
endmodule : xbp_ext_bus
`default_nettype wire

/* File: tb/xbp_ext_bus_sva.sv */
`default_nettype none
module xbp_ext_bus_sva
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire xbp_pkg::xbp_req_t req,
   input wire logic rsp_valid,
   input wire logic boot_rom_sel,
   input wire logic mode_wr,
   input wire logic mode_bit,
   input wire logic bus_hold_request_n,
   input wire xbp_pkg::xbp_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // =====================
   // Access shape
   sequence s_cycle(sig);
      !sig [*2] ##1 sig ##1 rsp_valid;
   endsequence
   a_strobe_excl: assert property (pins.rd_n || pins.wr_n)
      else $error("both strobes active");
   a_rnw_level: assert property (
      !pins.wr_n || !pins.rd_n |-> pins.rnw == pins.wr_n)
      else $error("rnw wrong");
   a_read_steps: assert property (
      $fell(pins.rd_n) |-> s_cycle(pins.rd_n))
      else $error("bad read cycle");
   a_write_steps: assert property (
      $fell(pins.wr_n) |-> s_cycle(pins.wr_n))
      else $error("bad write cycle");
   a_hold_float: assert property (
      !pins.grant_n |-> pins.bus_oe_n && pins.data_oe_n)
      else $error("bus driven in hold");
   a_hold_quiet: assert property (
      !pins.grant_n |-> pins.rd_n && pins.wr_n && pins.cs01_n
         && pins.cs2_n && pins.cs67_n)
      else $error("access started in hold");
   a_grant_idle: assert property (
      $fell(pins.grant_n) |-> $past(pins.rd_n && pins.wr_n))
      else $error("grant during access");
   a_grant_end: assert property (
      $rose(bus_hold_request_n) |-> ##[1:5] pins.grant_n)
      else $error("grant not released");
   a_low_pair: assert property (
      $fell(pins.cs01_n) |-> $past(req.zone) < 3'h2)
      else $error("low pair select wrong");
   a_zone_two: assert property (
      $fell(pins.cs2_n) |-> $past(req.zone) == 3'h2)
      else $error("zone two select wrong");
   a_high_pair: assert property (
      $fell(pins.cs67_n) |-> $past(req.zone) == 3'h6
         || ($past(req.zone) == 3'h7 && mode_bit))
      else $error("high pair select wrong");
   a_boot_rom: assert property (
      boot_rom_sel |-> !mode_bit && pins.cs67_n)
      else $error("boot rom path wrong");
   // Capture after reset lands within four cycles of the release
   a_mode_keep: assert property (
      $changed(mode_bit) && $past(reset_n, 4) |-> $past(mode_wr))
      else $error("mode bit moved");
endmodule : xbp_ext_bus_sva
bind xbp_ext_bus xbp_ext_bus_sva i_xbp_ext_bus_sva
(
   .mclk(mclk),
   .reset_n(reset_n),
   .req(req),
   .rsp_valid(rsp_valid),
   .boot_rom_sel(boot_rom_sel),
   .mode_wr(mode_wr),
   .mode_bit(mode_bit),
   .bus_hold_request_n(bus_hold_request_n),
   .pins(pins)
);
`default_nettype wire

/* File: tb/xbp_mem_model.sv */
`default_nettype none
module xbp_mem_model
(
   input wire logic mclk,
   input wire xbp_pkg::xbp_pins_t pins,
   output logic [15:0] data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [256];
   logic sel;
   assign sel = !pins.bus_oe_n && !(pins.cs01_n && pins.cs2_n && pins.cs67_n);
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = {8'hA5, i[7:0]};
   end
   always @(posedge mclk)
   begin
      if (sel && !pins.wr_n)
         mem[pins.addr[7:0]] <= pins.data;
   end
   always_comb
   begin
      if (!pins.data_oe_n)
         data_out = pins.data;
      else if (sel && pins.rnw)
         data_out = mem[pins.addr[7:0]];
      else
         data_out = 16'hFFFF;
   end
endmodule : xbp_mem_model
`default_nettype wire

/* File: tb/xbp_ext_bus_tb_top.sv */
`default_nettype none
module xbp_ext_bus_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, reset_n, mode_wr, mode_wdata, pin_mode, hold_n, mode, done;
   logic req_ready, rsp_valid, boot_rom_sel, mode_bit;
   logic [15:0] rsp_rdata, data_in;
   logic [31:0] r;
   xbp_pkg::xbp_req_t req;
   xbp_pkg::xbp_pins_t pins;
   int n_errors, compares, seed, model [256];
   logic [2:0] zones [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
   xbp_ext_bus i_xbp_ext_bus (.mclk(mclk), .reset_n(reset_n), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .boot_rom_sel(boot_rom_sel), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
      .mode_bit(mode_bit), .processor_mode_select(pin_mode),
      .bus_hold_request_n(hold_n), .pins(pins), .ext_data_bus_in(data_in));
   xbp_mem_model i_xbp_mem_model (.mclk(mclk), .pins(pins), .data_out(data_in));
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // =====================
   // Tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic end_sim;
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic acc(input logic w, input logic [2:0] z, input logic [18:0] a,
      input logic [15:0] d);
      logic rdy;
      logic [2:0] cs = 3'h0;
      logic [2:0] ecs;
      logic bs = 1'b0;
      int i;
      @(posedge mclk);
      req <= '{1'b1, w, z, a, d};
      // Take edge: ready seen high before it and low after it
      for (i = 0; i < 60; i++)
      begin
         @(negedge mclk);
         rdy = req_ready;
         @(posedge mclk);
         #1;
         if (rdy && !req_ready)
            break;
      end
      if (i == 60)
      begin
         n_errors++;
         end_sim();
      end
      // Boot ROM pulse stands only in the cycle after the take edge
      bs = boot_rom_sel;
      for (i = 0; i < 12 && !rsp_valid; i++)
      begin
         @(posedge mclk);
         if (i == 0)
            req.valid <= 1'b0;
         #1;
         cs |= {!pins.cs01_n, !pins.cs2_n, !pins.cs67_n};
         bs |= boot_rom_sel;
         if (!pins.rd_n || !pins.wr_n)
            chk(pins.addr, a);
         if (!pins.wr_n)
            chk(pins.data, d);
      end
      if (i == 12)
      begin
         n_errors++;
         end_sim();
      end
      ecs = {z < 3'h2, z == 3'h2, z == 3'h6 || (z == 3'h7 && mode)};
      chk(cs, ecs);
      chk(bs, z == 3'h7 && !mode);
      // External: strobe cycles then done; boot ROM: done only
      chk(i, (z == 3'h7 && !mode) ? 1 : xbp_pkg::STROBE_CYCLES + 1);
      if (!w && ecs != 3'h0)
         chk(rsp_rdata, model[a[7:0]]);
      if (w && ecs != 3'h0)
         model[a[7:0]] = d;
      done = 1'b1;
   endtask : acc
   task automatic rand_ops(input int n);
      repeat (n)
      begin
         r = $random(seed);
         acc(r[0], zones[r[3:1] % 5], {r[30:20], r[11:4]}, r[27:12]);
      end
   endtask : rand_ops
   task automatic wait_grant(input logic v);
      int i;
      for (i = 0; i < 20 && pins.grant_n !== v; i++)
      begin
         @(posedge mclk);
         #1;
      end
      chk(pins.grant_n, v);
      if (i == 20)
         end_sim();
   endtask : wait_grant
   // =====================
   // Main sequence
   initial
   begin
      seed = 19533;
      {reset_n, mode_wr, mode_wdata, done} = 4'h0;
      {pin_mode, hold_n, mode} = 3'h7;
      req = '0;
      for (int k = 0; k < 256; k++)
         model[k] = {8'hA5, k[7:0]};
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      pin_mode <= 1'b0;
      rand_ops(30);
      chk(mode_bit, 1'b1);
      @(posedge mclk);
      {mode_wr, mode_wdata} <= 2'h2;
      @(posedge mclk);
      mode_wr <= 1'b0;
      mode = 1'b0;
      rand_ops(20);
      chk(mode_bit, 1'b0);
      fork
         acc(1'b1, 3'h0, 19'h00011, 16'h1234);
         begin
            repeat (3) @(posedge mclk);
            hold_n <= 1'b0;
         end
      join
      wait_grant(1'b0);
      done = 1'b0;
      fork
         acc(1'b0, 3'h0, 19'h00011, 16'h0000);
         begin
            repeat (10) @(posedge mclk);
            chk(done, 1'b0);
            hold_n <= 1'b1;
            wait_grant(1'b1);
         end
      join
      end_sim();
   end
endmodule : xbp_ext_bus_tb_top
`default_nettype wire
